// ==== hw/bal_cfg.svh ====
// bal_cfg.svh: constants of the byte alu and flag logic
// assumes: included by bare name before the package and the modules
`ifndef BAL_CFG_SVH
`define BAL_CFG_SVH
`define BAL_W 8
`define BAL_MSB 7
`define BAL_NIB_HI 4
`define BAL_ZERO 8'h00
`define BAL_NIB_LIMIT 4'h9
`define BAL_DA_LO_ADJ 9'h006
`define BAL_DA_HI_ADJ 9'h060
`define BAL_DA_LIMIT 9'h099
`define BAL_MUL_LIMIT 16'h00ff
`endif

// ==== hw/bal_pkg.sv ====
// bal_pkg.sv: types of the byte alu and flag logic
// assumes: bal_cfg.svh sits in the include path
`include "bal_cfg.svh"
package bal_pkg;
  typedef logic [`BAL_W-1:0] bal_byte_t;
  typedef enum logic [3:0] {
    BAL_OP_NOP = 4'h0,
    BAL_OP_ADD = 4'h1,
    BAL_OP_ADDC = 4'h2,
    BAL_OP_SUBB = 4'h3,
    BAL_OP_MUL = 4'h4,
    BAL_OP_DIV = 4'h5,
    BAL_OP_DA = 4'h6,
    BAL_OP_RRC = 4'h7,
    BAL_OP_RLC = 4'h8,
    BAL_OP_CJNE = 4'h9
  } bal_op_e;
  typedef enum logic [1:0] {
    BAL_ST_IDLE = 2'h1,
    BAL_ST_DIV = 2'h2
  } bal_st_e;
  typedef enum logic [1:0] {
    BAL_DV_IDLE = 2'h1,
    BAL_DV_RUN = 2'h2
  } bal_dv_e;
  typedef struct packed {
    bal_byte_t res;
    logic carry;
    logic wrap;
    logic half;
  } bal_res_s;
endpackage

// ==== hw/bal_divider.sv ====
// bal_divider.sv: iterative restoring unsigned divider, one quotient bit a clock
// assumes: start is a one-cycle pulse and is not raised while a division runs
`timescale 1ns/10ps
`default_nettype none
`include "bal_cfg.svh"
module bal_divider #(
  parameter int unsigned W = `BAL_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [W-1:0] dividend,
  input wire logic [W-1:0] divisor,
  output logic done,
  output logic div_zero,
  output logic [W-1:0] quotient,
  output logic [W-1:0] remainder
);
  import bal_pkg::*;

  localparam int unsigned CW = $clog2(W);

  if (W < 2) begin : g_bad_width
    $error("bal_divider needs W of at least 2");
  end

  bal_dv_e state_q;
  logic [CW-1:0] cnt_q;
  logic [W-1:0] quo_q;
  logic [W-1:0] rem_q;
  logic [W-1:0] dsr_q;
  logic done_q;
  logic zero_q;
  logic [W:0] trial;
  logic fits;

  assign trial = {rem_q, quo_q[W-1]};
  assign fits = trial >= {1'b0, dsr_q};

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= BAL_DV_IDLE;
      cnt_q <= '0;
      quo_q <= '0;
      rem_q <= '0;
      dsr_q <= '0;
      done_q <= 1'b0;
      zero_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        BAL_DV_IDLE: begin
          if (start) begin
            dsr_q <= divisor;
            cnt_q <= '0;
            if (divisor == '0) begin
              // undefined result: all ones quotient, dividend left as remainder
              quo_q <= '1;
              rem_q <= dividend;
              zero_q <= 1'b1;
              done_q <= 1'b1;
            end else begin
              quo_q <= dividend;
              rem_q <= '0;
              zero_q <= 1'b0;
              state_q <= BAL_DV_RUN;
            end
          end
        end
        BAL_DV_RUN: begin
          rem_q <= fits ? W'(trial - {1'b0, dsr_q}) : trial[W-1:0];
          quo_q <= {quo_q[W-2:0], fits};
          cnt_q <= CW'(cnt_q + 1'b1);
          if (cnt_q == CW'(W - 1)) begin
            state_q <= BAL_DV_IDLE;
            done_q <= 1'b1;
          end
        end
        default: state_q <= BAL_DV_IDLE;
      endcase
    end
  end

  assign done = done_q;
  assign div_zero = zero_q;
  assign quotient = quo_q;
  assign remainder = rem_q;
endmodule
`default_nettype wire

// ==== hw/bal_alu.sv ====
// bal_alu.sv: byte alu of the core with accumulator, aux register and flags
// assumes: decoder drives one operation at a time, ops are refused while busy
`timescale 1ns/10ps
`default_nettype none
`include "bal_cfg.svh"
module bal_alu #(
  parameter int unsigned DATA_W = `BAL_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic op_valid,
  input wire bal_pkg::bal_op_e op_code,
  input wire bal_pkg::bal_byte_t op_src,
  input wire bal_pkg::bal_byte_t op_dst,
  input wire logic acc_wr,
  input wire bal_pkg::bal_byte_t acc_wr_data,
  input wire logic aux_wr,
  input wire bal_pkg::bal_byte_t aux_wr_data,
  input wire logic flags_wr,
  input wire logic carry_wr_data,
  input wire logic wrap_wr_data,
  input wire logic half_wr_data,
  output logic busy,
  output logic done,
  output logic branch_taken,
  output bal_pkg::bal_byte_t acc,
  output bal_pkg::bal_byte_t aux,
  output logic carry_flag,
  output logic signed_wrap_flag,
  output logic half_carry_flag
);
  import bal_pkg::*;

  // flag positions are fixed to a byte wide datapath
  if (DATA_W != `BAL_W) begin : g_bad_width
    $error("bal_alu supports a data width of 8 only");
  end

  //////////////////////////////////////////////////////////////////////////////
  // shared arithmetic

  function automatic bal_res_s add_sub(
    input bal_byte_t a,
    input bal_byte_t b,
    input logic cin,
    input logic sub
  );
    logic [`BAL_W:0] s;
    bal_res_s r;
    if (sub) begin
      s = {1'b0, a} - {1'b0, b} - {{`BAL_W{1'b0}}, cin};
    end else begin
      s = {1'b0, a} + {1'b0, b} + {{`BAL_W{1'b0}}, cin};
    end
    r.res = s[`BAL_W-1:0];
    // carry or borrow out of the top bit
    r.carry = s[`BAL_W];
    // carry or borrow across bit 6 into bit 7, mixed with the top one
    r.wrap = s[`BAL_W] ^ (a[`BAL_MSB] ^ b[`BAL_MSB] ^ s[`BAL_MSB]);
    // carry or borrow across bit 3 into bit 4
    r.half = a[`BAL_NIB_HI] ^ b[`BAL_NIB_HI] ^ s[`BAL_NIB_HI];
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state

  bal_st_e state_q;
  logic busy_q;
  logic done_q;
  logic branch_q;
  bal_byte_t acc_q;
  bal_byte_t aux_q;
  logic carry_q;
  logic wrap_q;
  logic half_q;

  logic take;
  logic div_start;
  logic div_done;
  logic div_zero;
  bal_byte_t div_quo;
  bal_byte_t div_rem;

  bal_res_s add_r;
  bal_res_s addc_r;
  bal_res_s subb_r;
  logic [2*`BAL_W-1:0] mul_p;
  logic da_lo_fix;
  logic da_hi_fix;
  logic [`BAL_W:0] da_step1;
  logic [`BAL_W:0] da_full;
  logic cmp_ne;
  logic cmp_gt;

  bal_byte_t acc_d;
  bal_byte_t aux_d;
  logic carry_d;
  logic wrap_d;
  logic half_d;
  logic acc_we;
  logic aux_we;
  logic carry_we;
  logic wrap_we;
  logic half_we;
  logic branch_d;

  assign take = op_valid && !busy_q;
  assign div_start = take && (op_code == BAL_OP_DIV);

  //////////////////////////////////////////////////////////////////////////////
  // operation results

  assign add_r = add_sub(acc_q, op_src, 1'b0, 1'b0);
  assign addc_r = add_sub(acc_q, op_src, carry_q, 1'b0);
  assign subb_r = add_sub(acc_q, op_src, carry_q, 1'b1);

  assign mul_p = {{`BAL_W{1'b0}}, acc_q} * {{`BAL_W{1'b0}}, aux_q};

  // low nibble fix, then high nibble fix
  assign da_lo_fix = half_q || (acc_q[`BAL_NIB_HI-1:0] > `BAL_NIB_LIMIT);
  assign da_step1 = {1'b0, acc_q} + (da_lo_fix ? `BAL_DA_LO_ADJ : '0);
  assign da_hi_fix = carry_q || da_lo_fix;
  assign da_full = da_step1 + (da_hi_fix ? `BAL_DA_HI_ADJ : '0);

  assign cmp_ne = op_src != op_dst;
  assign cmp_gt = op_src > op_dst;

  bal_divider #(
    .W(`BAL_W)
  ) u_div (
    .clk(clk),
    .nrst(nrst),
    .start(div_start),
    .dividend(acc_q),
    .divisor(aux_q),
    .done(div_done),
    .div_zero(div_zero),
    .quotient(div_quo),
    .remainder(div_rem)
  );

  //////////////////////////////////////////////////////////////////////////////
  // per operation selection of values and write enables

  always_comb begin
    acc_d = acc_q;
    aux_d = aux_q;
    carry_d = carry_q;
    wrap_d = wrap_q;
    half_d = half_q;
    acc_we = 1'b0;
    aux_we = 1'b0;
    carry_we = 1'b0;
    wrap_we = 1'b0;
    half_we = 1'b0;
    branch_d = 1'b0;
    case (op_code)
      BAL_OP_ADD: begin
        acc_d = add_r.res;
        carry_d = add_r.carry;
        wrap_d = add_r.wrap;
        half_d = add_r.half;
        acc_we = 1'b1;
        carry_we = 1'b1;
        wrap_we = 1'b1;
        half_we = 1'b1;
      end
      BAL_OP_ADDC: begin
        acc_d = addc_r.res;
        carry_d = addc_r.carry;
        wrap_d = addc_r.wrap;
        half_d = addc_r.half;
        acc_we = 1'b1;
        carry_we = 1'b1;
        wrap_we = 1'b1;
        half_we = 1'b1;
      end
      BAL_OP_SUBB: begin
        acc_d = subb_r.res;
        carry_d = subb_r.carry;
        wrap_d = subb_r.wrap;
        half_d = subb_r.half;
        acc_we = 1'b1;
        carry_we = 1'b1;
        wrap_we = 1'b1;
        half_we = 1'b1;
      end
      BAL_OP_MUL: begin
        acc_d = mul_p[`BAL_W-1:0];
        aux_d = mul_p[2*`BAL_W-1:`BAL_W];
        carry_d = 1'b0;
        wrap_d = mul_p > `BAL_MUL_LIMIT;
        acc_we = 1'b1;
        aux_we = 1'b1;
        carry_we = 1'b1;
        wrap_we = 1'b1;
      end
      BAL_OP_DA: begin
        acc_d = da_full[`BAL_W-1:0];
        carry_d = da_full > `BAL_DA_LIMIT;
        acc_we = 1'b1;
        carry_we = 1'b1;
      end
      BAL_OP_RRC: begin
        acc_d = {carry_q, acc_q[`BAL_MSB:1]};
        carry_d = acc_q[0];
        acc_we = 1'b1;
        carry_we = 1'b1;
      end
      BAL_OP_RLC: begin
        acc_d = {acc_q[`BAL_MSB-1:0], carry_q};
        carry_d = acc_q[`BAL_MSB];
        acc_we = 1'b1;
        carry_we = 1'b1;
      end
      BAL_OP_CJNE: begin
        carry_d = cmp_gt;
        carry_we = 1'b1;
        branch_d = cmp_ne;
      end
      // divide results land later from the divider
      BAL_OP_DIV: begin
        branch_d = 1'b0;
      end
      default: begin
        branch_d = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencing: single cycle ops complete at once, divide waits for the divider

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= BAL_ST_IDLE;
      busy_q <= 1'b0;
    end else begin
      case (state_q)
        BAL_ST_IDLE: begin
          if (div_start) begin
            state_q <= BAL_ST_DIV;
            busy_q <= 1'b1;
          end
        end
        BAL_ST_DIV: begin
          if (div_done) begin
            state_q <= BAL_ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: begin
          state_q <= BAL_ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'b0;
      branch_q <= 1'b0;
    end else begin
      done_q <= (take && (op_code != BAL_OP_DIV)) || div_done;
      branch_q <= take && branch_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // accumulator and aux: operation results win over direct loads

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= `BAL_ZERO;
    end else if (div_done) begin
      acc_q <= div_quo;
    end else if (take && acc_we) begin
      acc_q <= acc_d;
    end else if (acc_wr) begin
      acc_q <= acc_wr_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aux_q <= `BAL_ZERO;
    end else if (div_done) begin
      aux_q <= div_rem;
    end else if (take && aux_we) begin
      aux_q <= aux_d;
    end else if (aux_wr) begin
      aux_q <= aux_wr_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flags: each kept unless the operation names it

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      carry_q <= 1'b0;
    end else if (div_done) begin
      carry_q <= 1'b0;
    end else if (take && carry_we) begin
      carry_q <= carry_d;
    end else if (flags_wr) begin
      carry_q <= carry_wr_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrap_q <= 1'b0;
    end else if (div_done) begin
      wrap_q <= div_zero;
    end else if (take && wrap_we) begin
      wrap_q <= wrap_d;
    end else if (flags_wr) begin
      wrap_q <= wrap_wr_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      half_q <= 1'b0;
    end else if (take && half_we) begin
      half_q <= half_d;
    end else if (flags_wr) begin
      half_q <= half_wr_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops

  assign busy = busy_q;
  assign done = done_q;
  assign branch_taken = branch_q;
  assign acc = acc_q;
  assign aux = aux_q;
  assign carry_flag = carry_q;
  assign signed_wrap_flag = wrap_q;
  assign half_carry_flag = half_q;
endmodule
`default_nettype wire

// ==== tb/bal_alu_sva.sv ====
// bal_alu_sva.sv: concurrent checks on the byte alu ports
// assumes: bound to bal_alu from the bench top file
`timescale 1ns/10ps
`default_nettype none
module bal_alu_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic op_valid,
  input wire bal_pkg::bal_op_e op_code,
  input wire bal_pkg::bal_byte_t op_src,
  input wire bal_pkg::bal_byte_t op_dst,
  input wire logic busy,
  input wire logic done,
  input wire logic branch_taken,
  input wire bal_pkg::bal_byte_t acc,
  input wire bal_pkg::bal_byte_t aux,
  input wire logic carry_flag,
  input wire logic signed_wrap_flag,
  input wire logic half_carry_flag
);
  import bal_pkg::*;
  logic go;
  assign go = op_valid && !busy;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  property p_add;
    go && op_code == BAL_OP_ADD |=> done && {carry_flag, acc} == {1'b0, $past(acc)} + {1'b0, $past(op_src)};
  endproperty
  a_add: assert property (p_add) else $error("add result wrong");
  property p_addc;
    go && op_code == BAL_OP_ADDC |=> {carry_flag, acc} == {1'b0, $past(acc)} + {1'b0, $past(op_src)}
      + 9'($past(carry_flag));
  endproperty
  a_addc: assert property (p_addc) else $error("addc result wrong");
  property p_subb;
    go && op_code == BAL_OP_SUBB |=> {carry_flag, acc} == {1'b0, $past(acc)} - {1'b0, $past(op_src)}
      - 9'($past(carry_flag));
  endproperty
  a_subb: assert property (p_subb) else $error("subb result wrong");
  property p_mul;
    go && op_code == BAL_OP_MUL |=> {aux, acc} == 16'($past(acc)) * 16'($past(aux)) && !carry_flag
      && signed_wrap_flag == (aux != 8'h00);
  endproperty
  a_mul: assert property (p_mul) else $error("mul result wrong");
  property p_div;
    go && op_code == BAL_OP_DIV && aux != 8'h00 |=> busy [*8] ##1 busy
      ##1 (done && !busy && !carry_flag && !signed_wrap_flag
      && acc == $past(acc, 10) / $past(aux, 10) && aux == $past(acc, 10) % $past(aux, 10));
  endproperty
  a_div: assert property (p_div) else $error("div result or timing wrong");
  property p_div_zero;
    go && op_code == BAL_OP_DIV && aux == 8'h00 |=> busy ##1 (done && !busy && signed_wrap_flag && !carry_flag);
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("div by zero flags wrong");
  property p_rrc;
    go && op_code == BAL_OP_RRC |=> acc == ({$past(carry_flag), 7'h00} | ($past(acc) >> 1))
      && carry_flag == $past(acc[0]) && $stable(signed_wrap_flag);
  endproperty
  a_rrc: assert property (p_rrc) else $error("rrc result wrong");
  property p_rlc;
    go && op_code == BAL_OP_RLC |=> acc == {$past(acc[6:0]), $past(carry_flag)} && carry_flag == $past(acc[7]);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rlc result wrong");
  property p_cjne;
    go && op_code == BAL_OP_CJNE |=> done && branch_taken == ($past(op_src) != $past(op_dst))
      && carry_flag == ($past(op_src) > $past(op_dst)) && $stable(acc);
  endproperty
  a_cjne: assert property (p_cjne) else $error("cjne result wrong");
endmodule
`default_nettype wire

// ==== tb/bal_seq_model.sv ====
// bal_seq_model.sv: decoder-side model that loads registers and issues ops
// assumes: clk, busy and done come from the bench and the alu
`timescale 1ns/10ps
`default_nettype none
module bal_seq_model (
  input wire logic clk,
  input wire logic busy,
  input wire logic done,
  output logic op_valid,
  output bal_pkg::bal_op_e op_code,
  output bal_pkg::bal_byte_t op_src,
  output bal_pkg::bal_byte_t op_dst,
  output logic ld,
  output bal_pkg::bal_byte_t ld_acc,
  output bal_pkg::bal_byte_t ld_aux,
  output logic [2:0] ld_flags
);
  import bal_pkg::*;
  initial begin
    op_valid = 1'b0;
    op_code = BAL_OP_NOP;
    op_src = 8'h00;
    op_dst = 8'h00;
    ld = 1'b0;
    ld_acc = 8'h00;
    ld_aux = 8'h00;
    ld_flags = 3'h0;
  end
  task automatic load(input bal_byte_t a, input bal_byte_t b, input logic [2:0] f);
    @(posedge clk);
    ld <= 1'b1;
    ld_acc <= a;
    ld_aux <= b;
    ld_flags <= f;
    @(posedge clk);
    ld <= 1'b0;
    ld_acc <= ~a;
    ld_aux <= ~b;
  endtask
  // request stays up while busy; the edge after return takes it
  task automatic issue(input bal_op_e op, input bal_byte_t s, input bal_byte_t d);
    int n = 0;
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= op;
    op_src <= s;
    op_dst <= d;
    @(negedge clk);
    while (busy !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic drop();
    @(posedge clk);
    op_valid <= 1'b0;
    op_src <= ~op_src;
    op_dst <= ~op_dst;
  endtask
  task automatic wait_done();
    int n = 0;
    @(negedge clk);
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// tb_top.sv: self-checking bench of the byte alu
// assumes: bal_pkg, the checker and the decoder model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import bal_pkg::*;
  typedef struct {bal_op_e op; bal_byte_t a, b, s, d, ea, eb; logic [2:0] f, ef; logic br;} bal_row_s;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic op_valid, ld, busy, done, branch_taken, carry_flag, signed_wrap_flag, half_carry_flag;
  bal_op_e op_code;
  bal_byte_t op_src, op_dst, ld_acc, ld_aux, acc, aux;
  logic [2:0] ld_flags;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  // rows: op, acc, aux, src, dst, acc out, aux out, flags in, flags out {c,w,h}, branch
  bal_row_s rows [16] = '{
    '{BAL_OP_ADD, 8'h7f, 8'h00, 8'h01, 8'h00, 8'h80, 8'h00, 3'h4, 3'h3, 1'b0},
    '{BAL_OP_ADDC, 8'hf0, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 3'h4, 3'h5, 1'b0},
    '{BAL_OP_SUBB, 8'h80, 8'h00, 8'h01, 8'h00, 8'h7e, 8'h00, 3'h4, 3'h3, 1'b0},
    '{BAL_OP_SUBB, 8'h10, 8'h00, 8'h20, 8'h00, 8'hf0, 8'h00, 3'h0, 3'h4, 1'b0},
    '{BAL_OP_MUL, 8'h10, 8'h20, 8'h00, 8'h00, 8'h00, 8'h02, 3'h7, 3'h3, 1'b0},
    '{BAL_OP_MUL, 8'h0f, 8'h11, 8'h00, 8'h00, 8'hff, 8'h00, 3'h4, 3'h0, 1'b0},
    '{BAL_OP_DIV, 8'hfb, 8'h0a, 8'h00, 8'h00, 8'h19, 8'h01, 3'h7, 3'h1, 1'b0},
    '{BAL_OP_DIV, 8'h37, 8'h00, 8'h00, 8'h00, 8'hff, 8'h37, 3'h5, 3'h3, 1'b0},
    '{BAL_OP_DA, 8'h9a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 3'h4, 1'b0},
    '{BAL_OP_DA, 8'h15, 8'h00, 8'h00, 8'h00, 8'h7b, 8'h00, 3'h1, 3'h1, 1'b0},
    '{BAL_OP_DA, 8'h12, 8'h00, 8'h00, 8'h00, 8'h72, 8'h00, 3'h6, 3'h2, 1'b0},
    '{BAL_OP_RRC, 8'h81, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 3'h3, 3'h7, 1'b0},
    '{BAL_OP_RLC, 8'h81, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 3'h4, 3'h4, 1'b0},
    '{BAL_OP_CJNE, 8'h55, 8'h00, 8'h80, 8'h7f, 8'h55, 8'h00, 3'h2, 3'h6, 1'b1},
    '{BAL_OP_CJNE, 8'h55, 8'h00, 8'h42, 8'h42, 8'h55, 8'h00, 3'h4, 3'h0, 1'b0},
    '{BAL_OP_NOP, 8'h3c, 8'h5a, 8'h00, 8'h00, 8'h3c, 8'h5a, 3'h5, 3'h5, 1'b0}};
  always #5 clk = ~clk;
  bal_alu i_bal_alu (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code), .op_src(op_src),
    .op_dst(op_dst), .acc_wr(ld), .acc_wr_data(ld_acc), .aux_wr(ld), .aux_wr_data(ld_aux), .flags_wr(ld),
    .carry_wr_data(ld_flags[2]), .wrap_wr_data(ld_flags[1]), .half_wr_data(ld_flags[0]), .busy(busy),
    .done(done), .branch_taken(branch_taken), .acc(acc), .aux(aux), .carry_flag(carry_flag),
    .signed_wrap_flag(signed_wrap_flag), .half_carry_flag(half_carry_flag));
  bal_seq_model i_seq (.clk(clk), .busy(busy), .done(done), .op_valid(op_valid), .op_code(op_code),
    .op_src(op_src), .op_dst(op_dst), .ld(ld), .ld_acc(ld_acc), .ld_aux(ld_aux), .ld_flags(ld_flags));
  ////////////////////////////////////////////////////////////////
  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_f(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t flags got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic run(input bal_op_e op, input bal_byte_t s);
    i_seq.issue(op, s, 8'h00);
    i_seq.drop();
    i_seq.wait_done();
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      i_seq.load(rows[i].a, rows[i].b, rows[i].f);
      i_seq.issue(rows[i].op, rows[i].s, rows[i].d);
      i_seq.drop();
      i_seq.wait_done();
      chk_b(acc, rows[i].ea);
      chk_b(aux, rows[i].eb);
      chk_f({carry_flag, signed_wrap_flag, half_carry_flag}, rows[i].ef);
      chk_f({carry_flag, branch_taken, done}, {rows[i].ef[2], rows[i].br, 1'b1});
    end
    // add held while the divide runs must wait, then act once
    i_seq.load(8'h64, 8'h07, 3'h0);
    i_seq.issue(BAL_OP_DIV, 8'h00, 8'h00);
    run(BAL_OP_ADD, 8'h05);
    chk_b(acc, 8'h13);
    chk_f({carry_flag, signed_wrap_flag, half_carry_flag}, 3'h1);
    chk_f({1'b0, busy, done}, 3'h1);
    // reset in the middle of a divide
    i_seq.load(8'hc8, 8'h03, 3'h7);
    i_seq.issue(BAL_OP_DIV, 8'h00, 8'h00);
    i_seq.drop();
    repeat (3) @(posedge clk);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    chk_b(acc, 8'h00);
    chk_b(aux, 8'h00);
    chk_b({2'h0, busy, done, branch_taken, carry_flag, signed_wrap_flag, half_carry_flag}, 8'h00);
    nrst <= 1'b1;
    // back to back ops see the previous result
    i_seq.load(8'h01, 8'h00, 3'h0);
    i_seq.issue(BAL_OP_ADD, 8'h01, 8'h00);
    run(BAL_OP_ADDC, 8'h01);
    chk_b(acc, 8'h03);
    report_and_stop();
  end
endmodule
bind bal_alu bal_alu_chk i_chk (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code), .op_src(op_src),
  .op_dst(op_dst), .busy(busy), .done(done), .branch_taken(branch_taken), .acc(acc), .aux(aux),
  .carry_flag(carry_flag), .signed_wrap_flag(signed_wrap_flag), .half_carry_flag(half_carry_flag));
`default_nettype wire
